// ===== verilog/ssl_selftest.sv
// Safety and self-test logic for a two-channel sensor transceiver.
// Assumes a register master on a plain strobe port and analog flags
// that are already synchronous to i_mclk.
// Function
// - Software tag per slot, returned with data
// - Data frame carries fault summary bit
// - Tag and data stored in one write
// - After valid read, write empty code, check
// - Failed check latches fault, read clears
// - Test bit keeps old data after read
// - Test level drives selected output statically
// - Select field decodes output one or two
// - At most one output in test mode
// - Start only with both lines off
// - Ignore line-on and regulator-off while testing
// - Only stop bit works; master abort flags
// - Running flag during test, done after
// - Results clear on read or start request
// - Bits 0,8 hold master ground results
// - Slave sinks 512 us, checks undervolt
// - Master battery check each line in turn
// - Battery short excludes line from coupling
// - Phase one drives line one, checks both
// - Phase two drives line two, checks both
// - Master ends itself; slave abort unflagged
// - Undervolt filtered, only while line on
// - Reset keeps lines off, clears failures
//
// The address-and-strobe port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module ssl_selftest #(
    parameter int FILT_CYC = 16
) (
    input  wire logic           i_mclk,
    input  wire logic           i_rst_n,
    input  wire logic [7:0]     i_addr,
    input  wire logic [31:0]    i_wdata,
    input  wire logic           i_wr,
    input  wire logic           i_rd,
    output logic [31:0]         o_rdata,
    input  wire ssl_pkg::ssl_rx_t i_rx_one,
    input  wire ssl_pkg::ssl_rx_t i_rx_two,
    input  wire logic [ssl_pkg::SLOT_AW-1:0] i_slot,
    input  wire logic [1:0]     i_line_uv_raw,
    input  wire logic [1:0]     i_line_bat_short,
    input  wire logic [1:0]     i_line_gnd_short,
    input  wire logic           i_reg_undervolt,
    input  wire logic [1:0]     i_dout,
    output logic [1:0]          o_dout,
    output logic [1:0]          o_line_on,
    output logic [1:0]          o_sink,
    output logic                o_fault_mask,
    output logic                o_reg_disable
);
    import ssl_pkg::*;

    // ************************************************************
    // Declarations
    // ************************************************************
    logic          srst;
    logic          rst;
    ssl_xstate_t   st;
    logic          ch;
    logic [9:0]    tmr;
    logic [4:0]    div;
    logic          us_tick;
    logic          run;
    logic          exp;
    logic [10:0]   sts_q;
    logic          bet;
    logic [1:0]    sw_line;
    logic          reg_dis;
    logic [15:0]   crit;
    logic [7:0]    par_cnt;
    logic          par_bad;
    logic          reg_uv;
    logic          fsum;
    logic [TAG_W-1:0] tag_mem [2**(SLOT_AW+1)];
    logic          wr_ok;
    logic          start_req;
    logic          abort_req;
    logic          rd_sr2;
    logic [1:0]    done_abrt;
    logic [1:0]    bsh;
    logic [1:0]    cres;
    logic [1:0]    xgnd;
    logic          gnd_hold;
    logic [1:0]    uvf;
    logic [1:0]    bef;
    logic [1:0]    gnd_view;
    logic [1:0]    test_en;
    logic [31:0]   sr2;
    ssl_buf_t      bufs [2];
    ssl_rx_t       rx [2];

    assign rx[0] = i_rx_one;
    assign rx[1] = i_rx_two;
    assign rst   = !i_rst_n || srst;
    assign run   = (st != X_IDLE);
    assign exp   = us_tick && (tmr == 10'd1);
    // While a test runs every write except the abort is dropped
    assign wr_ok = i_wr && !run;
    assign start_req = wr_ok && i_addr == A_STS
                       && (i_wdata[STS_SLAVE] || i_wdata[STS_MASTER]);
    assign abort_req = i_wr && i_addr == A_ABORT && i_wdata[ABORT_STOP];
    assign rd_sr2    = i_rd && i_addr == A_SR2;
    assign fsum      = reg_uv || par_bad;
    // Held ground results replace the live view after a master test
    assign gnd_view  = gnd_hold ? xgnd : i_line_gnd_short;
    assign sr2 = {16'h0, 3'h0, cres[1], bsh[1], uvf[1], bef[1], gnd_view[1],
                  done_abrt[1], done_abrt[0], run,
                  cres[0], bsh[0], uvf[0], bef[0], gnd_view[0]};

    // ************************************************************
    // Soft reset and microsecond enable
    // ************************************************************
    // Soft reset lasts one cycle; a running test drops it like any other write
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            srst <= 1'b0;
        end else begin
            srst <= wr_ok && i_addr == A_LINE && i_wdata[LINE_SRST];
        end
    end

    // One enable pulse per microsecond drives every test timer
    always_ff @(posedge i_mclk) begin
        if (rst) begin
            div     <= 5'h0;
            us_tick <= 1'b0;
        end else begin
            us_tick <= (div == US_DIV);
            div     <= (div == US_DIV) ? 5'h0 : div + 5'h1;
        end
    end

    // ************************************************************
    // Software registers
    // ************************************************************
    always_ff @(posedge i_mclk) begin
        if (rst) begin
            sts_q   <= 11'h0;
            bet     <= 1'b0;
            sw_line <= 2'b00;
            reg_dis <= 1'b0;
            crit    <= CRIT_RST;
        end else if (wr_ok) begin
            case (i_addr)
                A_STS:  sts_q <= i_wdata[10:0];
                A_SELF_TEST_STATUS_REG: bet   <= i_wdata[SELF_TEST_STATUS_REG_BET];
                A_LINE: begin
                    sw_line <= i_wdata[1:0];
                    reg_dis <= i_wdata[LINE_REG_DIS];
                end
                A_CRIT: crit <= i_wdata[15:0];
                default: ;
            endcase
        end
    end

    // Slot tag table, one entry per slot of each channel
    always_ff @(posedge i_mclk) begin
        if (wr_ok && i_addr[7:4] == A_TAG_HI) begin
            tag_mem[i_addr[3:0]] <= i_wdata[TAG_W-1:0];
        end
    end

    // Parity of the critical register is checked every 150 us
    always_ff @(posedge i_mclk) begin
        if (rst) begin
            par_cnt <= 8'h0;
            par_bad <= 1'b0;
            reg_uv  <= 1'b0;
        end else begin
            reg_uv <= i_reg_undervolt;
            if (us_tick) begin
                par_cnt <= (par_cnt == PAR_TK - 8'h1) ? 8'h0 : par_cnt + 8'h1;
                if (par_cnt == PAR_TK - 8'h1) begin
                    par_bad <= !(^crit);
                end
            end
        end
    end

    // ************************************************************
    // Per-channel buffer and undervolt filter
    // ************************************************************
    for (genvar c = 0; c < 2; c++) begin : g_ch
        logic       chk;
        logic [4:0] fcnt;
        logic       rd_me;
        assign rd_me = i_rd && i_addr == A_DATA1 + 8'(c);

        // Tag and data land together; a clear never beats fresh data
        always_ff @(posedge i_mclk) begin
            if (rst) begin
                bufs[c] <= '{tag: '0, data: EMPTY_CODE};
                chk     <= 1'b0;
                bef[c]  <= 1'b0;
            end else begin
                chk <= 1'b0;
                if (rx[c].valid) begin
                    bufs[c] <= '{tag: tag_mem[{1'(c), i_slot}],
                                 data: rx[c].data};
                end else if (rd_me && bufs[c].data != EMPTY_CODE) begin
                    if (!bet) begin
                        bufs[c].data <= EMPTY_CODE;
                    end
                    chk <= 1'b1;
                end
                if (rd_sr2) begin
                    bef[c] <= 1'b0;
                end
                if (chk && bufs[c].data != EMPTY_CODE) begin
                    bef[c] <= 1'b1;
                end
            end
        end

        // Debounce counts only while the line is powered
        always_ff @(posedge i_mclk) begin
            if (rst || !o_line_on[c]) begin
                fcnt   <= 5'h0;
                uvf[c] <= 1'b0;
            end else if (i_line_uv_raw[c] == uvf[c]) begin
                fcnt <= 5'h0;
            end else if (fcnt == 5'(FILT_CYC - 1)) begin
                fcnt   <= 5'h0;
                uvf[c] <= i_line_uv_raw[c];
            end else begin
                fcnt <= fcnt + 5'h1;
            end
        end

        bufchk_a: assert property (@(posedge i_mclk) disable iff (rst)
            rd_me && !rx[c].valid && !bet && bufs[c].data != EMPTY_CODE
            |=> bufs[c].data == EMPTY_CODE ##1 !$rose(bef[c]))
            else $error("buffer not emptied after read");
        beflatch_a: assert property (@(posedge i_mclk) disable iff (rst)
            chk && bufs[c].data != EMPTY_CODE |=> bef[c])
            else $error("buffer empty fault not latched");
    end

    // ************************************************************
    // Cross-coupling test sequencer
    // ************************************************************
    // The sequencer owns the line, sink and mask outputs
    always_ff @(posedge i_mclk) begin
        if (rst) begin
            st <= X_IDLE;
            ch <= 1'b0;
            tmr <= 10'h0;
            o_line_on <= 2'b00;
            o_sink <= 2'b00;
            o_fault_mask <= 1'b0;
            done_abrt <= 2'b00;
            bsh <= 2'b00;
            cres <= 2'b00;
            xgnd <= 2'b00;
            gnd_hold <= 1'b0;
        end else begin
            if (us_tick && tmr != 10'h0) begin
                tmr <= tmr - 10'h1;
            end
            if (rd_sr2) begin
                done_abrt <= 2'b00;
                bsh <= 2'b00;
                cres <= 2'b00;
                xgnd <= 2'b00;
                gnd_hold <= 1'b0;
            end
            case (st)
                X_IDLE: begin
                    o_line_on <= sw_line;
                    if (start_req) begin
                        done_abrt <= 2'b00;
                        bsh <= 2'b00;
                        cres <= 2'b00;
                        xgnd <= 2'b00;
                        gnd_hold <= 1'b0;
                        if (o_line_on == 2'b00 && sw_line == 2'b00) begin
                            tmr <= SETTLE_TK;
                            if (i_wdata[STS_MASTER]) begin
                                st <= X_BON;
                                ch <= 1'b0;
                                o_line_on <= 2'b01;
                                o_fault_mask <= 1'b1;
                            end else begin
                                st <= X_SLV;
                                o_sink <= 2'b11;
                            end
                        end
                    end
                end
                X_SLV: if (exp) begin
                    o_sink <= 2'b00;
                    cres <= ~i_line_uv_raw;
                    done_abrt[1] <= 1'b1;
                    st <= X_IDLE;
                end
                X_BON, X_CON: if (exp) begin
                    if (st == X_BON) begin
                        bsh[ch] <= i_line_bat_short[ch];
                    end else begin
                        xgnd[ch] <= i_line_uv_raw[ch];
                        if (!i_line_uv_raw[!ch]) begin
                            cres[!ch] <= 1'b1;
                        end
                    end
                    o_line_on <= 2'b00;
                    o_sink <= ch ? 2'b10 : 2'b01;
                    tmr <= DRAIN_TK;
                    st <= (st == X_BON) ? X_BDCH : X_CDCH;
                end
                X_BDCH, X_CDCH: if (exp) begin
                    o_sink <= 2'b00;
                    tmr <= SETTLE_TK;
                    if (st == X_BDCH && !ch) begin
                        ch <= 1'b1;
                        o_line_on <= 2'b10;
                        st <= X_BON;
                    end else if (st == X_BDCH && !(bsh[0] && bsh[1])) begin
                        ch <= bsh[0];
                        o_line_on <= bsh[0] ? 2'b10 : 2'b01;
                        st <= X_CON;
                    end else if (st == X_CDCH && !ch && !bsh[1]) begin
                        ch <= 1'b1;
                        o_line_on <= 2'b10;
                        st <= X_CON;
                    end else begin
                        done_abrt[1] <= 1'b1;
                        gnd_hold <= 1'b1;
                        o_fault_mask <= 1'b0;
                        st <= X_IDLE;
                    end
                end
                default: st <= X_IDLE;
            endcase
            // Abort drops every drive at once
            if (abort_req && run) begin
                st <= X_IDLE;
                o_line_on <= 2'b00;
                o_sink <= 2'b00;
                o_fault_mask <= 1'b0;
                if (st != X_SLV) begin
                    done_abrt[0] <= 1'b1;
                end
            end
        end
    end

    // ************************************************************
    // Output test, read port and registered pins
    // ************************************************************
    // Only two select codes exist, so both outputs never test together
    assign test_en = {sts_q[9:STS_SEL_LO] == SEL_TWO,
                      sts_q[9:STS_SEL_LO] == SEL_ONE};

    always_ff @(posedge i_mclk) begin
        if (rst) begin
            o_dout <= 2'b00;
            o_reg_disable <= 1'b0;
        end else begin
            for (int k = 0; k < 2; k++) begin
                o_dout[k] <= test_en[k] ? sts_q[STS_LVL] : i_dout[k];
            end
            o_reg_disable <= reg_dis;
        end
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge i_mclk) begin
        if (rst || !i_rd) begin
            o_rdata <= 32'h0;
        end else begin
            case (i_addr)
                A_STS:   o_rdata <= {21'h0, sts_q};
                A_SELF_TEST_STATUS_REG:  o_rdata <= {31'h0, bet};
                A_SR2:   o_rdata <= sr2;
                A_LINE:  o_rdata <= {29'h0, reg_dis, o_line_on};
                A_CRIT:  o_rdata <= {16'h0, crit};
                A_DATA1: o_rdata <= {10'h0, fsum, bufs[0]};
                A_DATA2: o_rdata <= {10'h0, fsum, bufs[1]};
                default: o_rdata <= (i_addr[7:4] == A_TAG_HI)
                                    ? {27'h0, tag_mem[i_addr[3:0]]} : 32'h0;
            endcase
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (rst);

    sequence s_abort;
        abort_req && run;
    endsequence

    start_off_a: assert property ($rose(run) |-> $past(o_line_on) == 2'b00)
        else $error("test started with a line on");
    refuse_a: assert property (start_req && o_line_on != 2'b00
        |=> !run && done_abrt == 2'b00 && cres == 2'b00)
        else $error("refused start not handled");
    line_cmd_a: assert property (run && i_wr && i_addr == A_LINE
        |=> $stable(sw_line) && $stable(reg_dis))
        else $error("line command taken during test");
    abort_mst_a: assert property (s_abort and st != X_SLV
        |=> !run && o_line_on == 2'b00 && o_sink == 2'b00 && done_abrt[0])
        else $error("master abort mishandled");
    abort_slv_a: assert property (s_abort and st == X_SLV
        |=> !done_abrt[0] && o_sink == 2'b00)
        else $error("slave abort raised flag");
    slave_sink_a: assert property (st == X_SLV |-> o_sink == 2'b11
        && o_line_on == 2'b00)
        else $error("slave sink wrong");
    one_line_a: assert property (o_fault_mask |-> o_line_on != 2'b11)
        else $error("both lines on in master test");
    excl_a: assert property (st == X_CON |-> !bsh[ch])
        else $error("excluded line used in coupling");
    test_one_a: assert property ($onehot0(test_en) and
        (test_en[1] |=> o_dout[1] == $past(sts_q[STS_LVL])))
        else $error("output test level wrong");
    hold_gnd_a: assert property ($fell(run) && done_abrt[1] && $past(st) != X_SLV
        |-> gnd_hold && sr2[0] == xgnd[0] && sr2[8] == xgnd[1])
        else $error("ground result not held");
    rel_off_a: assert property ($fell(rst) |-> o_line_on == 2'b00
        && bef == 2'b00)
        else $error("lines not off after reset");
endmodule

// ===== common/ssl_pkg.sv
// Shared constants, register map and carrier types of the sensor link
// safety and self-test block. Assumes a 20 MHz device clock.
package ssl_pkg;
    // ************************************************************
    // Clock and times
    // ************************************************************
    localparam int CLK_HZ     = 20_000_000;
    localparam int US_CYC     = CLK_HZ / 1_000_000;   // Cycles per microsecond
    localparam int T_SETTLE_US = 512;
    localparam int T_DRAIN_US  = 128;
    localparam int T_PAR_US    = 150;
    localparam logic [9:0] SETTLE_TK = 10'(T_SETTLE_US);
    localparam logic [9:0] DRAIN_TK  = 10'(T_DRAIN_US);
    localparam logic [7:0] PAR_TK    = 8'(T_PAR_US);
    localparam logic [4:0] US_DIV    = 5'(US_CYC - 1);
    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] A_STS   = 8'h01;   // Self-test setting
    localparam logic [7:0] A_ABORT = 8'h02;   // Abort command
    localparam logic [7:0] A_SELF_TEST_STATUS_REG  = 8'h03;   // Self-test status
    localparam logic [7:0] A_SR2   = 8'h04;   // Status two, read clears
    localparam logic [7:0] A_LINE  = 8'h05;   // Line and regulator control
    localparam logic [7:0] A_CRIT  = 8'h06;   // Critical, odd parity
    localparam logic [7:0] A_DATA1 = 8'h08;
    localparam logic [7:0] A_DATA2 = 8'h09;
    localparam logic [3:0] A_TAG_HI = 4'h1;   // Tags at 0x10..0x1f
    // ************************************************************
    // Fields and reset values
    // ************************************************************
    localparam int STS_SLAVE = 0;
    localparam int STS_MASTER = 1;
    localparam int STS_LVL   = 10;
    localparam int STS_SEL_LO = 5;
    localparam logic [4:0] SEL_ONE = 5'h15;
    localparam logic [4:0] SEL_TWO = 5'h16;
    localparam int LINE_REG_DIS = 2;
    localparam int LINE_SRST    = 3;
    localparam int ABORT_STOP   = 0;
    localparam int SELF_TEST_STATUS_REG_BET     = 0;
    localparam int TAG_W  = 5;
    localparam int DATA_W = 16;
    localparam int SLOT_AW = 3;
    localparam logic [15:0] EMPTY_CODE = 16'h01f0;
    localparam logic [15:0] CRIT_RST   = 16'h8000;
    typedef enum logic [2:0] {
        X_IDLE = 3'b000,
        X_SLV  = 3'b001,
        X_BON  = 3'b010,
        X_BDCH = 3'b011,
        X_CON  = 3'b100,
        X_CDCH = 3'b101
    } ssl_xstate_t;
    typedef struct packed {
        logic              valid;
        logic [DATA_W-1:0] data;
    } ssl_rx_t;
    typedef struct packed {
        logic [TAG_W-1:0]  tag;
        logic [DATA_W-1:0] data;
    } ssl_buf_t;
endpackage

// ===== dv/ssl_line_model.sv
// Sensor line model: turns line and sink enables into comparator levels.
// Assumes registered enables from the self-test block on one clock.
`timescale 1ns/1ps
module ssl_line_model (
    input  wire logic       i_mclk,
    input  wire logic       i_couple,
    input  wire logic [1:0] i_line_on,
    input  wire logic [1:0] i_sink,
    output logic [1:0]      o_uv
);
    // ********************
    // Line voltage
    // ********************
    // A line is up only while powered; a coupling fault lifts the other
    // line too. Sink current wins, so a drained line always reads low.
    always_ff @(posedge i_mclk) begin
        o_uv[0] <= ~((i_line_on[0] | (i_couple & i_line_on[1])) & ~i_sink[0]);
        o_uv[1] <= ~((i_line_on[1] | (i_couple & i_line_on[0])) & ~i_sink[1]);
    end
endmodule

// ===== dv/ssl_selftest_tb.sv
// Self-checking bench: register port, sensor words, output test mode
// and both coupling test modes. Assumes the line model beside it.
`timescale 1ns/1ps
module ssl_selftest_tb;
    import ssl_pkg::*;
    logic        i_mclk, i_rst_n, i_wr, i_rd, couple, reg_uv, mask, reg_dis;
    logic [7:0]  i_addr;
    logic [31:0] i_wdata, o_rdata, d, tmp;
    logic [31:0] seed = 32'hba8f;
    ssl_rx_t     rx_one, rx_two;
    logic [2:0]  slot;
    logic [1:0]  uv, bat, gnd, din, dout, line_on, sink;
    logic [4:0]  sels [4] = '{SEL_ONE, SEL_TWO, 5'h00, 5'h17};
    int          err_count = 0, check_count = 0, cyc = 0;
    // ********************
    // Helpers
    // ********************
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Only the selected output is overridden, the other passes through
    function automatic logic [1:0] exp_dout(logic [4:0] s, logic l, logic [1:0] n);
        exp_dout = n;
        if (s == SEL_ONE) exp_dout[0] = l;
        if (s == SEL_TWO) exp_dout[1] = l;
    endfunction
    task automatic chk(logic [31:0] seen, logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wt(int n);
        repeat (n) @(posedge i_mclk);
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] v);
        @(posedge i_mclk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= v;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(logic [7:0] a);
        @(posedge i_mclk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask
    task automatic rxrd(logic [15:0] v);
        @(posedge i_mclk);
        rx_one <= {1'b1, v};
        @(posedge i_mclk);
        rx_one <= {1'b0, v};
        rd(A_DATA1);
    endtask
    task automatic report_and_stop();
        $display("checks=%0d errors=%0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ********************
    // Clock, hang guard, instances
    // ********************
    initial begin
        i_mclk = 1'b0;
        forever #25 i_mclk = ~i_mclk;
    end
    always @(posedge i_mclk) begin
        cyc++;
        if (cyc == 80000) begin
            err_count++;
            report_and_stop();
        end
    end
    ssl_selftest #(.FILT_CYC(2)) ssl_selftest_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_rx_one(rx_one), .i_rx_two(rx_two), .i_slot(slot), .i_line_uv_raw(uv),
        .i_line_bat_short(bat), .i_line_gnd_short(gnd), .i_reg_undervolt(reg_uv),
        .i_dout(din), .o_dout(dout), .o_line_on(line_on), .o_sink(sink),
        .o_fault_mask(mask), .o_reg_disable(reg_dis));
    ssl_line_model ssl_line_model_inst (.i_mclk(i_mclk), .i_couple(couple),
        .i_line_on(line_on), .i_sink(sink), .o_uv(uv));
    // ********************
    // Main sequence
    // ********************
    initial begin
        {i_rst_n, i_wr, i_rd, couple, reg_uv, i_addr, i_wdata} = '0;
        {rx_one, rx_two, slot, bat, gnd, din} = '0;
        wt(12);
        i_rst_n <= 1'b1;
        wt(2);
        chk({line_on, sink, reg_dis}, 5'h00);
        for (int k = 0; k < 8; k++) begin
            tmp = rnd();
            din <= tmp[1:0];
            wr(A_STS, {21'h0, tmp[2], sels[k % 4], 5'h00});
            wt(2);
            chk(dout, exp_dout(sels[k % 4], tmp[2], din));
        end
        wr(A_STS, 32'h0);
        tmp = rnd();
        slot <= tmp[2:0];
        wr(8'h10 | {5'h0, tmp[2:0]}, {27'h0, tmp[7:3]});
        wr(8'h18 | {5'h0, tmp[2:0]}, {27'h0, ~tmp[7:3]});
        rx_two <= {1'b1, tmp[23:8]};
        @(posedge i_mclk);
        rx_two <= {1'b0, tmp[23:8]};
        rd(A_DATA2);
        chk(d, {11'h0, ~tmp[7:3], tmp[23:8]});
        rxrd({tmp[31:24], 8'h5a});
        chk(d, {11'h0, tmp[7:3], tmp[31:24], 8'h5a});
        rd(A_DATA1);
        chk(d[15:0], EMPTY_CODE);
        reg_uv <= 1'b1;
        rxrd(16'h1234);
        chk(d[21], 1'b1);
        reg_uv <= 1'b0;
        wr(A_CRIT, 32'h0003); // even parity on purpose
        wt(3100);
        rxrd(16'h2345);
        chk(d[21], 1'b1);
        wr(A_CRIT, 32'h8000);
        wt(3100);
        rxrd(16'h3456);
        chk(d[21], 1'b0);
        wr(A_SELF_TEST_STATUS_REG, 32'h1);
        rxrd(16'h4567);
        wt(3);
        rd(A_DATA1);
        chk(d[15:0], 16'h4567);
        wt(3);
        rd(A_SR2);
        chk(d[1], 1'b1);
        rd(A_SR2);
        chk(d[1], 1'b0);
        wr(A_SELF_TEST_STATUS_REG, 32'h0);
        wr(A_STS, 32'h1);
        wr(A_LINE, 32'h7);
        wt(2);
        chk({line_on, sink, reg_dis}, 5'b00110);
        rd(A_SR2);
        chk(d[5], 1'b1);
        wt(10300);
        rd(A_SR2);
        chk({d[12], d[7:4]}, 5'b01000);
        couple <= 1'b1;
        bat <= 2'b10;
        wr(A_STS, 32'h2);
        wt(3);
        chk({line_on, sink, mask}, 5'b01001);
        wt(11500);
        chk({line_on, sink}, 4'b0001);
        wt(6500);
        chk({line_on, sink}, 4'b1000);
        wt(25000);
        chk(line_on, 2'b00);
        wt(8400);
        gnd <= 2'b11;
        rd(A_SR2);
        chk(d[12:0] & 13'h1bfb, 13'h1880);
        rd(A_SR2);
        chk({d[8], d[0], d[7]}, 3'b110);
        {gnd, bat, couple} <= '0;
        wr(A_STS, 32'h2);
        wt(100);
        wr(A_ABORT, 32'h1);
        wt(2);
        chk({line_on, sink}, 4'h0);
        rd(A_SR2);
        chk(d[7:5], 3'b010);
        wr(A_STS, 32'h1);
        wt(50);
        wr(A_ABORT, 32'h1);
        wt(2);
        chk({line_on, sink}, 4'h0);
        rd(A_SR2);
        chk(d[7:5], 3'b000);
        wr(A_LINE, 32'h1);
        wr(A_STS, 32'h2);
        wt(3);
        chk({line_on, sink, mask}, 5'b01000);
        wr(A_LINE, 32'h4);
        wt(2);
        chk({line_on, reg_dis}, 3'b001);
        report_and_stop();
    end
endmodule
